// ===== dpram_pkg.sv
// Package of constants for the dual-ported transfer memory
package dpram_pkg;
   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int unsigned MEM_BYTES = 2048;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned WORDS = MEM_BYTES / 2;
   localparam int unsigned IDX_W = $clog2(WORDS);
   // Base of the window: top 2 Kbytes of a 16 Kbyte implemented space
   localparam logic [15:0] BASE_ADDR = 16'h3800;
   localparam logic [15:0] RESET_WORD = 16'h0000;

   // ----------------------------------------
   // Address helpers
   // ----------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:IDX_W+1] == BASE_ADDR[ADDR_W-1:IDX_W+1];
   endfunction : hit

   function automatic logic [IDX_W-1:0] idx(input logic [ADDR_W-1:0] a);
      return a[IDX_W:1];
   endfunction : idx
endpackage : dpram_pkg

// ===== dpram_port.sv
// One access port: address decode, byte lane enables, byte select on the core's registered read data
`timescale 1ns/1ps
`default_nettype none
module dpram_port (
   input wire logic clk,
   input wire logic nrst,
   // Request
   input wire logic en,
   input wire logic we,
   input wire logic byte_op,
   input wire logic [15:0] addr,
   // Decoded
   output logic sel,
   output logic [9:0] widx,
   output logic [1:0] lanes,
   // Read path
   input wire logic [15:0] word_in,
   input wire logic lsb_q_in,
   input wire logic byte_q_in,
   output logic [15:0] rdata
);
   always_comb begin
      sel = en && dpram_pkg::hit(addr);
      widx = dpram_pkg::idx(addr);
      // Byte writes touch only the addressed half
      if (!(sel && we)) lanes = 2'b00;
      else if (!byte_op) lanes = 2'b11;
      else lanes = addr[0] ? 2'b10 : 2'b01;
   end

   // Byte reads return the selected byte in the low lane
   always_comb begin
      if (!byte_q_in) rdata = word_in;
      else rdata = {8'h00, lsb_q_in ? word_in[15:8] : word_in[7:0]};
   end
endmodule : dpram_port
`default_nettype wire

// ===== dpram_core.sv
// Dual-ported transfer memory shared by CPU and DMA
//
// What this block does
// RULE1: 2 Kbyte memory placed at the top of the implemented data space.
// RULE2: Separate CPU and DMA ports, both may access any location each cycle.
// RULE3: DMA accesses never stall the CPU; no wait states ever.
// RULE4: Same-cycle writes to one location: CPU data is what remains.
// RULE5: DMA uses the memory as source and destination buffer.
// RULE6: Without DMA the memory serves as plain read/write storage.
// RULE7: 16-bit words, byte addressing; byte writes touch the selected half only.
// RULE8: A losing DMA write is dropped silently with no delay to either port.
`timescale 1ns/1ps
`default_nettype none
module dpram_core (
   input wire logic clk,
   input wire logic nrst,
   // CPU port
   input wire logic cpu_en,
   input wire logic cpu_we,
   input wire logic cpu_byte,
   input wire logic [15:0] cpu_addr,
   input wire logic [15:0] cpu_wdata,
   output logic [15:0] cpu_rdata,
   output logic cpu_ready,
   // DMA port
   input wire logic dma_en,
   input wire logic dma_we,
   input wire logic dma_byte,
   input wire logic [15:0] dma_addr,
   input wire logic [15:0] dma_wdata,
   output logic [15:0] dma_rdata,
   output logic dma_ready
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [15:0] mem [dpram_pkg::WORDS];
   logic c_sel, d_sel;
   logic [9:0] c_idx, d_idx;
   logic [1:0] c_ln, d_ln, d_ln_eff;
   logic [15:0] c_word_q, d_word_q;
   logic c_lsb_q, d_lsb_q, c_byte_q, d_byte_q;

   dpram_port u_cpu (
      .clk(clk), .nrst(nrst), .en(cpu_en), .we(cpu_we), .byte_op(cpu_byte),
      .addr(cpu_addr), .sel(c_sel), .widx(c_idx), .lanes(c_ln),
      .word_in(c_word_q), .lsb_q_in(c_lsb_q), .byte_q_in(c_byte_q), .rdata(cpu_rdata)
   );
   dpram_port u_dma (
      .clk(clk), .nrst(nrst), .en(dma_en), .we(dma_we), .byte_op(dma_byte),
      .addr(dma_addr), .sel(d_sel), .widx(d_idx), .lanes(d_ln),
      .word_in(d_word_q), .lsb_q_in(d_lsb_q), .byte_q_in(d_byte_q), .rdata(dma_rdata)
   );

   // Neither port ever waits
   assign cpu_ready = 1'b1; // RULE3
   assign dma_ready = 1'b1; // RULE3

   // ----------------------------------------
   // Collision: CPU lanes mask DMA lanes
   // ----------------------------------------
   // Per-lane masking so a CPU byte write still lets the other DMA byte land
   assign d_ln_eff = (c_idx == d_idx) ? (d_ln & ~c_ln) : d_ln; // RULE4 RULE8

   // ----------------------------------------
   // Write path
   // ----------------------------------------
   // Memory contents are not reset: a RAM array has no reset network
   always_ff @(posedge clk) begin
      for (int b = 0; b < 2; b++) begin
         if (c_ln[b]) mem[c_idx][b*8 +: 8] <= cpu_wdata[b*8 +: 8]; // RULE7 RULE4
         if (d_ln_eff[b]) mem[d_idx][b*8 +: 8] <= dma_wdata[b*8 +: 8]; // RULE7 RULE2
      end
   end

   // ----------------------------------------
   // Read path, one cycle latency, old data on write
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         c_word_q <= dpram_pkg::RESET_WORD;
         c_lsb_q <= 1'b0;
         c_byte_q <= 1'b0;
      end else begin
         // Outside the window read as zero
         c_word_q <= c_sel ? mem[c_idx] : dpram_pkg::RESET_WORD; // RULE1 RULE6
         c_lsb_q <= cpu_addr[0];
         c_byte_q <= cpu_byte;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         d_word_q <= dpram_pkg::RESET_WORD;
         d_lsb_q <= 1'b0;
         d_byte_q <= 1'b0;
      end else begin
         d_word_q <= d_sel ? mem[d_idx] : dpram_pkg::RESET_WORD; // RULE2 RULE5
         d_lsb_q <= dma_addr[0];
         d_byte_q <= dma_byte;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_cpu_no_wait: assert property (cpu_ready) // RULE3
      else $error("CPU port stalled");
   a_dma_no_wait: assert property (dma_ready) // RULE3
      else $error("DMA port stalled");
   a_cpu_wins: assert property (c_ln == 2'b11 && d_sel && c_idx == d_idx |-> d_ln_eff == 2'b00) // RULE4
      else $error("DMA write not dropped on collision");
   a_dma_drop_lane: assert property ((d_ln_eff & c_ln) == 2'b00 || c_idx != d_idx) // RULE8
      else $error("Both ports wrote one byte");
   a_byte_lane: assert property (c_sel && cpu_we && cpu_byte |-> $onehot(c_ln)) // RULE7
      else $error("Byte write touched both halves");
   a_word_lane: assert property (c_sel && cpu_we && !cpu_byte |-> c_ln == 2'b11) // RULE7
      else $error("Word write missed a lane");
   a_outside_zero: assert property (cpu_en && !c_sel |=> cpu_rdata == 16'h0000) // RULE1
      else $error("Read outside window not zero");

   // ----------------------------------------
   // Access sequences
   // ----------------------------------------
   // Word read taken on the CPU side
   sequence s_cpu_rd_word;
      c_sel && !cpu_we && !cpu_byte;
   endsequence

   // Byte read taken on the CPU side
   sequence s_cpu_rd_byte;
      c_sel && !cpu_we && cpu_byte;
   endsequence

   // Word read taken on the DMA side
   sequence s_dma_rd_word;
      d_sel && !dma_we && !dma_byte;
   endsequence

   // Byte read taken on the DMA side
   sequence s_dma_rd_byte;
      d_sel && !dma_we && dma_byte;
   endsequence

   // Full word written by the CPU
   sequence s_cpu_wr_word;
      c_ln == 2'b11;
   endsequence

   // Even byte written by the CPU
   sequence s_cpu_wr_low;
      c_ln == 2'b01;
   endsequence

   // Odd byte written by the CPU
   sequence s_cpu_wr_high;
      c_ln == 2'b10;
   endsequence

   // DMA word write with no CPU write to that word
   sequence s_dma_wr_alone;
      d_ln == 2'b11 && (c_ln == 2'b00 || c_idx != d_idx);
   endsequence

   // CPU even byte against a DMA word on one location
   sequence s_clash_low;
      c_ln == 2'b01 && d_ln == 2'b11 && c_idx == d_idx;
   endsequence

   // ----------------------------------------
   // Read checks
   // ----------------------------------------
   // Old data on a same-cycle write, so no collision term is needed
   a_cpu_readback: assert property (s_cpu_rd_word |=> cpu_rdata == $past(mem[c_idx])) // RULE6
      else $error("CPU read data wrong");

   a_dma_readback: assert property (s_dma_rd_word |=> dma_rdata == $past(mem[d_idx])) // RULE2
      else $error("DMA read data wrong");

   a_cpu_byte_rd: assert property (s_cpu_rd_byte |=> cpu_rdata[15:8] == 8'h00 && // RULE7
      cpu_rdata[7:0] == ($past(cpu_addr[0]) ? $past(mem[c_idx][15:8]) : $past(mem[c_idx][7:0])))
      else $error("CPU byte read wrong");

   a_dma_byte_rd: assert property (s_dma_rd_byte |=> dma_rdata[15:8] == 8'h00 && // RULE7
      dma_rdata[7:0] == ($past(dma_addr[0]) ? $past(mem[d_idx][15:8]) : $past(mem[d_idx][7:0])))
      else $error("DMA byte read wrong");

   a_dma_outside_zero: assert property (dma_en && !d_sel |=> dma_rdata == 16'h0000) // RULE1
      else $error("DMA read outside window not zero");

   // ----------------------------------------
   // Write checks
   // ----------------------------------------
   // CPU data always lands, whatever the DMA side does
   a_cpu_word_store: assert property (s_cpu_wr_word |=> mem[$past(c_idx)] == $past(cpu_wdata)) // RULE4
      else $error("CPU word write lost");

   a_cpu_low_store: assert property (s_cpu_wr_low |=> // RULE7
      mem[$past(c_idx)][7:0] == $past(cpu_wdata[7:0]))
      else $error("CPU even byte write lost");

   a_cpu_high_store: assert property (s_cpu_wr_high |=> // RULE7
      mem[$past(c_idx)][15:8] == $past(cpu_wdata[15:8]))
      else $error("CPU odd byte write lost");

   a_dma_word_store: assert property (s_dma_wr_alone |=> // RULE2
      mem[$past(d_idx)] == $past(dma_wdata))
      else $error("DMA word write lost");

   // Only the clashing lane is dropped; the other DMA byte must still land
   a_dma_lane_kept: assert property (s_clash_low |=> // RULE8
      mem[$past(d_idx)][15:8] == $past(dma_wdata[15:8]))
      else $error("Free DMA lane dropped");

   // ----------------------------------------
   // Window checks
   // ----------------------------------------
   a_cpu_in_window: assert property (c_sel |-> cpu_addr >= dpram_pkg::BASE_ADDR) // RULE1
      else $error("CPU hit below window");

   a_dma_in_window: assert property (d_sel |-> dma_addr >= dpram_pkg::BASE_ADDR) // RULE1
      else $error("DMA hit below window");
endmodule : dpram_core
`default_nettype wire

// ===== dma_model.sv
// DMA-side port model for the shared transfer memory
`timescale 1ns/1ps
`default_nettype none
module dma_model (
   input wire logic clk,
   // DMA request
   output logic en,
   output logic we,
   output logic byte_op,
   output logic [15:0] addr,
   output logic [15:0] wdata,
   // Answer
   input wire logic [15:0] rdata
);
   initial begin
      en = 1'b0;
      we = 1'b0;
      byte_op = 1'b0;
      addr = 16'h0000;
      wdata = 16'h0000;
   end
   // One access, buffer fill or drain; released data is inverted, never left stale
   task automatic acc(input logic w, input logic b, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] rq);
      @(negedge clk);
      en = 1'b1;
      we = w;
      byte_op = b;
      addr = a;
      wdata = d;
      @(negedge clk);
      rq = rdata;
      en = 1'b0;
      wdata = ~d;
   endtask : acc
endmodule : dma_model
`default_nettype wire

// ===== dual_port_dma_ram_tb.sv
// Self-checking bench for the dual-ported transfer memory
`timescale 1ns/1ps
`default_nettype none
module dual_port_dma_ram_tb;
   logic clk, nrst, cpu_en, cpu_we, cpu_byte, cpu_ready, dma_ready;
   logic dma_en, dma_we, dma_byte;
   logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, dma_addr, dma_wdata, dma_rdata, q, r;
   int error_cnt = 0;
   int compares = 0;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   dpram_core dut (.clk(clk), .nrst(nrst), .cpu_en(cpu_en), .cpu_we(cpu_we),
      .cpu_byte(cpu_byte), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata), .cpu_ready(cpu_ready), .dma_en(dma_en), .dma_we(dma_we),
      .dma_byte(dma_byte), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
      .dma_rdata(dma_rdata), .dma_ready(dma_ready));
   dma_model u_dma (.clk(clk), .en(dma_en), .we(dma_we), .byte_op(dma_byte),
      .addr(dma_addr), .wdata(dma_wdata), .rdata(dma_rdata));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cpu(input logic w, input logic b, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] rq);
      @(negedge clk);
      cpu_en = 1'b1;
      cpu_we = w;
      cpu_byte = b;
      cpu_addr = a;
      cpu_wdata = d;
      @(negedge clk);
      rq = cpu_rdata;
      chk({15'h0000, cpu_ready}, 16'h0001);
      cpu_en = 1'b0;
      cpu_wdata = ~d;
   endtask : cpu
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   // About 20 accesses of two cycles each; ample margin
   initial begin
      #20000;
      error_cnt++;
      print_verdict();
   end
   task automatic test_store;
      // Plain storage, both window ends, outside reads zero
      cpu(1, 0, 16'h3800, 16'hA5A5, q);
      cpu(1, 0, 16'h3FFE, 16'h5AC3, q);
      cpu(0, 0, 16'h3800, 16'h0000, q);
      chk(q, 16'hA5A5);
      cpu(0, 0, 16'h3FFE, 16'h0000, q);
      chk(q, 16'h5AC3);
      cpu(0, 0, 16'h37FE, 16'h0000, q);
      chk(q, 16'h0000);
      $display("store test done");
   endtask : test_store
   task automatic test_share;
      // Both ports together, then a same-word write clash
      fork cpu(1, 0, 16'h3802, 16'h1234, q); u_dma.acc(1, 0, 16'h3804, 16'h5678, r); join
      fork cpu(0, 0, 16'h3804, 16'h0000, q); u_dma.acc(0, 0, 16'h3802, 16'h0000, r); join
      chk(q, 16'h5678);
      chk(r, 16'h1234);
      chk({15'h0000, dma_ready}, 16'h0001);
      fork cpu(1, 0, 16'h3806, 16'hAAAA, q); u_dma.acc(1, 0, 16'h3806, 16'h5555, r); join
      u_dma.acc(0, 0, 16'h3806, 16'h0000, r);
      chk(r, 16'hAAAA);
      // CPU even byte against DMA word: DMA odd byte still lands
      fork cpu(1, 1, 16'h380A, 16'h00EE, q); u_dma.acc(1, 0, 16'h380A, 16'h7766, r); join
      cpu(0, 0, 16'h380A, 16'h0000, q);
      chk(q, 16'h77EE);
      $display("share test done");
   endtask : test_share
   task automatic test_byte;
      // Byte lanes: odd byte write keeps the even lane
      cpu(1, 0, 16'h3808, 16'h0011, q);
      cpu(1, 1, 16'h3809, 16'hC300, q);
      cpu(0, 0, 16'h3808, 16'h0000, q);
      chk(q, 16'hC311);
      u_dma.acc(0, 1, 16'h3809, 16'h0000, r);
      chk(r, 16'h00C3);
      $display("byte test done");
   endtask : test_byte
   task automatic test_reset;
      // Mid-run reset: read data clears, memory contents stay
      @(negedge clk);
      nrst = 1'b0;
      repeat (3) @(negedge clk);
      chk(cpu_rdata, 16'h0000);
      nrst = 1'b1;
      cpu(0, 0, 16'h3800, 16'h0000, q);
      chk(q, 16'hA5A5);
      $display("reset test done");
   endtask : test_reset
   initial begin
      {cpu_en, cpu_we, cpu_byte, cpu_addr, cpu_wdata} = '0;
      nrst = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      test_store();
      test_share();
      test_byte();
      test_reset();
      print_verdict();
   end
endmodule : dual_port_dma_ram_tb
`default_nettype wire
